// ==== rtl/led_fault_regs.v ====
/*
 Register bank: string 3/4 status, fault register, LED current setting,
 and the active-low fault flag output.
 Assumes a serial bus front end on clk_sys delivering address, write strobe,
 data and a read-done pulse at the end of each read transaction. Live
 analog detector levels arrive asynchronously and are synchronised here.
*/
`default_nettype none
`include "led_fault_consts.vh"
module led_fault_regs #(
	parameter [`HOLD_W-1:0] HOLD_CYCLES = `HOLD_CYCLES
) (
	input  wire       clk_sys,
	input  wire       rst_b,
	input  wire       enable,
	input  wire [7:0] reg_addr,
	input  wire [7:0] wr_data,
	input  wire       wr_stb,
	input  wire       rd_done,
	output reg  [7:0] rd_data,
	input  wire [1:0] sink_drain_overvolt,
	input  wire [1:0] string_open_det,
	input  wire       overcurrent_live,
	input  wire       overcurrent_shutdown_live,
	input  wire       over_temp_live,
	input  wire       temp_warning_live,
	output reg  [6:0] led_current_code,
	output reg        analog_dim_select,
	output wire       fault_flag_out_b
);
	// Index 0 = string 3, index 1 = string 4
	reg [1:0] unused_r;
	reg [1:0] overvolt_r;
	reg [1:0] open_r;
	reg       ocsd_r;
	reg       oc_r;
	reg       ot_r;
	reg       tw_r;
	reg [7:0] s1_r;
	reg [7:0] s2_r;
	reg       en_s1_r;
	reg       en_s2_r;
	reg       ot_prev_r;
	reg       tw_prev_r;
	wire      hold_active;
	wire [1:0] ov_live  = s2_r[1:0];
	wire [1:0] op_live  = s2_r[3:2];
	wire      oc_live   = s2_r[4];
	wire      ocsd_live = s2_r[5];
	wire      ot_live   = s2_r[6];
	wire      tw_live   = s2_r[7];
	wire      fault_rd  = rd_done && (reg_addr == `ADDR_FAULT); // [R17]
	wire      en_low    = !en_s2_r;
	// Report masked at once; stored flags only clear an edge later
	wire [1:0] ov_rep   = overvolt_r & ~unused_r; // [R01]
	wire [1:0] op_rep   = open_r & ~unused_r; // [R01]

	// Pins come from analog detectors outside this clock domain
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s1_r    <= 8'h00;
			s2_r    <= 8'h00;
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
		end else begin
			s1_r    <= {temp_warning_live, over_temp_live, overcurrent_shutdown_live,
				overcurrent_live, string_open_det, sink_drain_overvolt};
			s2_r    <= s1_r;
			en_s1_r <= enable;
			en_s2_r <= en_s1_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_str
			// Enable low or the string's unused bit clears string faults
			always @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					overvolt_r[i] <= 1'b0;
					open_r[i]     <= 1'b0;
				end else if (unused_r[i]) begin
					overvolt_r[i] <= 1'b0; // [R01]
					open_r[i]     <= 1'b0;
				end else if (en_low) begin
					overvolt_r[i] <= 1'b0;
					open_r[i]     <= 1'b0;
				end else begin
					if (ov_live[i])
						overvolt_r[i] <= 1'b1; // [R02]
					if (op_live[i])
						open_r[i] <= 1'b1; // [R04]
				end
			end
		end
	endgenerate

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			unused_r          <= 2'b00;
			{analog_dim_select, led_current_code} <= `CURRENT_RESET; // [R12]
		end else if (wr_stb) begin
			if (reg_addr == `ADDR_STR34) begin
				unused_r[1] <= wr_data[`BIT_STR4_UNUSED]; // [R01]
				unused_r[0] <= wr_data[`BIT_STR3_UNUSED];
			end else if (reg_addr == `ADDR_CURRENT) begin
				analog_dim_select <= wr_data[7]; // [R10]
				led_current_code  <= wr_data[6:0]; // [R11]
			end
		end
	end

	// Set wins over a clear arriving the same cycle
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ocsd_r    <= 1'b0;
			oc_r      <= 1'b0;
			ot_r      <= 1'b0;
			tw_r      <= 1'b0;
			ot_prev_r <= 1'b0;
			tw_prev_r <= 1'b0;
		end else begin
			ot_prev_r <= ot_live;
			tw_prev_r <= tw_live;
			if (ocsd_live)
				ocsd_r <= 1'b1;
			else if (fault_rd || en_low)
				ocsd_r <= 1'b0; // [R05]
			if (oc_live)
				oc_r <= 1'b1;
			else if (fault_rd || en_low)
				oc_r <= 1'b0; // [R06]
			if (ot_live && !ot_prev_r)
				ot_r <= 1'b1; // [R07] [R14]
			else if (fault_rd && !ot_live)
				ot_r <= 1'b0; // [R13] [R14]
			if (tw_live && !tw_prev_r)
				tw_r <= 1'b1; // [R08]
			else if (fault_rd && !tw_live)
				tw_r <= 1'b0; // [R09]
		end
	end

	always @* begin
		if (reg_addr == `ADDR_STR34) begin
			rd_data = {unused_r[0], unused_r[1], ov_rep[0], op_rep[0], unused_r[0],
				ov_rep[1], op_rep[1], unused_r[1]}; // [R03]
		end else if (reg_addr == `ADDR_FAULT) begin
			rd_data = {4'h0, ocsd_r, oc_r, ot_r, tw_r};
		end else if (reg_addr == `ADDR_CURRENT) begin
			rd_data = {analog_dim_select, led_current_code};
		end else begin
			rd_data = 8'h00;
		end
	end

	// Masked strings never reach the flag
	wire fault_any = (|ov_rep) | (|op_rep) | ocsd_r | oc_r | ot_r | tw_r; // [R01] [R15]

	flag_hold_timer #(
		.HOLD_CYCLES (HOLD_CYCLES)
	) u_hold (
		.clk_sys       (clk_sys),
		.rst_b         (rst_b),
		.fault_any     (fault_any),
		.hold_active_r (hold_active)
	);

	assign fault_flag_out_b = !(fault_any | hold_active); // [R15] [R16]
endmodule // led_fault_regs
`default_nettype wire

// ==== rtl/led_fault_consts.vh ====
/*
 Constants for the LED driver fault and current-setting register bank.
 Assumes inclusion by bare name from design files under rtl/.
*/
// What this block does
// [R01] Unused bit six masks string four faults
// [R02] Over-voltage flags set when drain exceeds threshold
// [R03] Not-used bits report strings treated unused
// [R04] Open flags set when string open detected
// [R05] Overcurrent-shutdown bit clears on read, enable low
// [R06] Overcurrent bit clears on read, enable low
// [R07] Over-temperature bit latches on rising edge
// [R08] Warning bit latches on rising edge
// [R09] Warning clears after read and live low
// [R10] Bit seven selects analog dimming source
// [R11] Seven-bit code sets current reference voltage
// [R12] Current setting resets to 0x7f
// [R13] Over-temp and flag clear after read, low
// [R14] Flag set and clear within one microsecond
// [R15] Fault flag is NOR of all faults
// [R16] Fault flag held low about 8 ms
// [R17] Clear-on-read acts at read completion
`ifndef LED_FAULT_CONSTS_VH
`define LED_FAULT_CONSTS_VH
`define ADDR_STR34      8'h06
`define ADDR_FAULT      8'h07
`define ADDR_CURRENT    8'h08
`define CURRENT_RESET   8'h7f
`define STR34_RESET     8'h00
`define BIT_STR4_UNUSED 6
`define BIT_STR3_UNUSED 7
`define BIT_OCSD        3
`define BIT_OC          2
`define BIT_OT          1
`define BIT_TW          0
// 8 ms at 20 MHz; sized to the counter so nothing is cut
`define HOLD_CYCLES     18'd160000
`define HOLD_W          18
`define VIS_BASE_MV     46
`define VIS_STEP_MV     2
`endif

// ==== rtl/flag_hold_timer.v ====
/*
 Holds the fault flag low for a fixed count after faults clear.
 Assumes one clock domain; fault_any is synchronous to clk_sys.
*/
`default_nettype none
`include "led_fault_consts.vh"
module flag_hold_timer #(
	parameter [`HOLD_W-1:0] HOLD_CYCLES = `HOLD_CYCLES
) (
	input  wire clk_sys,
	input  wire rst_b,
	input  wire fault_any,
	output reg  hold_active_r
);
	reg [`HOLD_W-1:0] cnt_r;
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r         <= {`HOLD_W{1'b0}};
			hold_active_r <= 1'b0;
		end else if (fault_any) begin
			cnt_r         <= HOLD_CYCLES; // [R16]
			hold_active_r <= 1'b1;
		end else if (cnt_r != {`HOLD_W{1'b0}}) begin
			cnt_r         <= cnt_r - {{(`HOLD_W-1){1'b0}}, 1'b1};
			hold_active_r <= (cnt_r != {{(`HOLD_W-1){1'b0}}, 1'b1});
		end else begin
			hold_active_r <= 1'b0;
		end
	end
endmodule // flag_hold_timer
`default_nettype wire

// ==== verification/led_fault_props.sv ====
/* Checker for the fault and current bank. Assumes one clock domain. */
`default_nettype none
module led_fault_props #(parameter int HOLD_CYCLES = 20) (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic       wr_stb,
	input wire logic [7:0] rd_data,
	input wire logic       over_temp_live,
	input wire logic       temp_warning_live,
	input wire logic       overcurrent_live,
	input wire logic [6:0] led_current_code,
	input wire logic       analog_dim_select,
	input wire logic       fault_flag_out_b);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [17:0] low_r;
	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b) low_r <= '0;
		else low_r <= fault_flag_out_b ? '0 : low_r + 1'b1;
	sequence s_wr(a); wr_stb && reg_addr == a; endsequence
	sequence s_ot; $rose(over_temp_live) ##1 over_temp_live [*3]; endsequence
	sequence s_tw; $rose(temp_warning_live) ##1 temp_warning_live [*3]; endsequence
	a_curr_reset: assert property ($rose(rst_b) |-> {analog_dim_select, led_current_code} == 8'h7f)
		else $error("bad reset code");
	a_code_write: assert property (s_wr(8'h08) |=>
		{analog_dim_select, led_current_code} == $past(wr_data)) else $error("write lost");
	a_code_read: assert property (reg_addr == 8'h08 |->
		rd_data == {analog_dim_select, led_current_code}) else $error("bad readback");
	a_ot_flag: assert property (s_ot |-> !fault_flag_out_b) else $error("flag late");
	a_tw_flag: assert property (s_tw |-> !fault_flag_out_b) else $error("flag late");
	a_oc_flag: assert property ($rose(overcurrent_live) |-> ##[1:4] !fault_flag_out_b) else $error("no flag");
	a_flag_hold: assert property ($rose(fault_flag_out_b) |-> low_r > HOLD_CYCLES) else $error("short hold");
	a_str4_mask: assert property (reg_addr == 8'h06 && rd_data[6] |-> rd_data[2:0] == 3'b001)
		else $error("not masked");
endmodule // led_fault_props
bind led_fault_regs led_fault_props #(.HOLD_CYCLES(HOLD_CYCLES)) led_fault_props_i (.*);
`default_nettype wire

// ==== verification/host_bus.sv ====
/* Host model on the register path. Assumes requests sampled on clk_sys. */
`default_nettype none
module host_bus (
	input  wire logic       clk_sys,
	input  wire logic [7:0] rd_data,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] wr_data,
	output var  logic       wr_stb,
	output var  logic       rd_done);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reg_addr, wr_data, wr_stb, rd_done} = '0;
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys) #2;
		{reg_addr, wr_data, wr_stb} = {a, d, 1'b1};
		@(posedge clk_sys) #2;
		wr_stb = 0;
		wr_data = ~d; // Released data must not look valid
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys) #2;
		{reg_addr, rd_done} = {a, 1'b1};
		// Taken at the accepting edge, before that edge's clear lands
		@(posedge clk_sys) d = rd_data;
		#2 rd_done = 0;
	endtask
endmodule // host_bus
`default_nettype wire

// ==== verification/test_led_fault_regs.sv ====
/* Bench for the fault bank. Assumes host_bus and a hold of 20 cycles. */
`default_nettype none
module test_led_fault_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, rst_b = 0, enable = 0, ot = 0, tw = 0, oc = 0, ocsd = 0, we, rdn, dim, flag_b;
	logic [1:0] ovv = 0, opn = 0;
	logic [7:0] adr, wd, rdd, d, val;
	logic [6:0] code;
	logic [31:0] lfsr = 32'hcd9e;
	int err_count = 0, n_compared = 0;
	led_fault_regs #(.HOLD_CYCLES(18'd20)) led_fault_regs_i (.clk_sys(clk_sys), .rst_b(rst_b), .enable(enable),
		.reg_addr(adr), .wr_data(wd), .wr_stb(we), .rd_done(rdn), .rd_data(rdd), .sink_drain_overvolt(ovv),
		.string_open_det(opn), .overcurrent_live(oc), .overcurrent_shutdown_live(ocsd), .over_temp_live(ot),
		.temp_warning_live(tw), .led_current_code(code), .analog_dim_select(dim), .fault_flag_out_b(flag_b));
	host_bus host_bus_i (.clk_sys(clk_sys), .rd_data(rdd), .reg_addr(adr), .wr_data(wd), .wr_stb(we), .rd_done(rdn));
	function automatic logic [3:0] bitv(input int b);
		return 4'h1 << b;
	endfunction
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic rc(input logic [7:0] a, exp);
		host_bus_i.rd(a, d);
		chk("reg", d, exp);
	endtask
	task automatic results;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial forever #25 clk_sys = ~clk_sys;
	initial begin
		#2000000;
		err_count++;
		results;
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		#2 {rst_b, enable} = 2'b11;
		chk("flag", {7'h0, flag_b}, 8'h01);
		chk("code", {dim, code}, 8'h7f);
		rc(8'h08, 8'h7f);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			val = i == 0 ? 8'h80 : (i == 1 ? 8'h00 : lfsr[7:0]);
			host_bus_i.wr(8'h08, val);
			chk("code", {dim, code}, val);
			rc(8'h08, val);
		end
		for (int b = 0; b < 4; b++) begin
			{ocsd, oc, ot, tw} = bitv(b);
			repeat (6) @(posedge clk_sys);
			#2 {ocsd, oc, ot, tw} = 4'h0;
			repeat (6) @(posedge clk_sys);
			rc(8'h07, {4'h0, bitv(b)});
			rc(8'h07, 8'h00);
		end
		chk("flag", {7'h0, flag_b}, 8'h00);
		repeat (24) @(posedge clk_sys);
		#2 chk("flag", {7'h0, flag_b}, 8'h01);
		tw = 1;
		repeat (6) @(posedge clk_sys);
		rc(8'h07, 8'h01);
		rc(8'h07, 8'h01);
		tw = 0;
		repeat (6) @(posedge clk_sys);
		rc(8'h07, 8'h01);
		rc(8'h07, 8'h00);
		oc = 1;
		repeat (6) @(posedge clk_sys);
		#2 {oc, enable} = 2'b00;
		repeat (6) @(posedge clk_sys);
		#2 enable = 1;
		repeat (6) @(posedge clk_sys);
		rc(8'h07, 8'h00);
		{ovv, opn} = 4'hf;
		repeat (6) @(posedge clk_sys);
		rc(8'h06, 8'h36);
		host_bus_i.wr(8'h06, 8'h40);
		rc(8'h06, 8'h71);
		host_bus_i.wr(8'h06, 8'hc0);
		rc(8'h06, 8'hc9);
		results;
	end
endmodule // test_led_fault_regs
`default_nettype wire
